// ### hw/acl_action_pkg.sv
// Purpose: Shared types and constants for the action decoder.
// Assumes: IPv4 addresses for source/destination IP rewrites.
// Notes: Register offsets are byte addresses on a 32-bit Wishbone bus.
package acl_action_pkg;

  // ***********************************
  // Register map
  // ***********************************
  localparam logic [7:0] OFS_SWAP_IP_CONTROL = 8'h00;
  localparam logic [7:0] OFS_EGR_DELAY = 8'h04;
  localparam logic [7:0] OFS_IGR_DELAY_A = 8'h08;
  localparam logic [7:0] OFS_IGR_DELAY_B = 8'h0C;
  localparam logic [7:0] OFS_PORT_SMAC_LO = 8'h10;
  localparam logic [7:0] OFS_PORT_SMAC_HI = 8'h14;
  localparam logic [7:0] OFS_TDOM_BASE = 8'h18;
  localparam logic [7:0] OFS_HIT_COUNT = 8'h28;
  localparam logic [7:0] OFS_LAST_TAG = 8'h2C;
  localparam logic [7:0] OFS_SIP_BASE = 8'h80;
  localparam int TTL_LSB = 0;
  localparam int TTL_W = 8;
  localparam int DCNT_LSB = 8;
  localparam int DCNT_W = 6;
  localparam int DELAY_W = 16;
  localparam int TDOM_W = 16;
  localparam int TDOM_N = 4;
  localparam int SIP_N = 32;
  localparam int SIP_AW = 5;
  localparam int MAC_W = 48;
  localparam int IP_W = 32;
  localparam logic [31:0] REG_RESET = 32'h0000_0000;

  // ***********************************
  // Field positions
  // ***********************************
  localparam int MAC_MC_BIT = 40;
  localparam logic [3:0] IP4_MC_NIBBLE = 4'hE;
  localparam logic [3:0] MODE_DMAC_PARTIAL = 4'h8;
  localparam int LOG_OFFSET = 8;

  typedef enum logic [1:0] {
    TTL_KEEP = 2'b00, TTL_DEC = 2'b01, TTL_PRESET = 2'b10
  } ttl_op_t;

  typedef struct packed {
    logic valid;
    logic lookup;
    logic [7:0] rewrite_command;
    logic ttl_decrement_enable;
    logic service_activation_only;
    logic l4_port_rewrite_enable;
    logic [15:0] entry_logical_tag;
    logic [15:0] entry_tag_mask;
    logic [11:0] counter_index;
    logic mac_exchange_enable;
    logic [2:0] log_interval_code;
    logic [3:0] route_swap_mode;
    logic [MAC_W-1:0] replacement_mac;
    logic [1:0] timing_domain_select;
    logic policer_enable;
    logic [4:0] policer_index;
    logic cpu_copy_enable;
    logic service_activation_sequence;
    logic delay_resp_frame;
    logic [MAC_W-1:0] frame_smac;
    logic [MAC_W-1:0] frame_dmac;
    logic [IP_W-1:0] frame_sip;
    logic [IP_W-1:0] frame_dip;
  } action_in_t;

  typedef struct packed {
    logic valid;
    logic [7:0] rewrite_command;
    logic [1:0] ptp_op;
    logic [DELAY_W-1:0] delay_add;
    logic seq_insert;
    logic dresp_enable;
    logic dresp_receipt_update;
    logic [TDOM_W-1:0] timing_domain_cfg;
    ttl_op_t ttl_op;
    logic [TTL_W-1:0] ttl_value;
    logic l4_rewrite;
    logic [15:0] l4_dport;
    logic [15:0] l4_sport;
    logic cpu_copy;
    logic [15:0] header_class_result;
    logic cnt_update;
    logic cnt_lookup;
    logic [11:0] counter_index;
    logic [MAC_W-1:0] new_dmac;
    logic [MAC_W-1:0] new_smac;
    logic [IP_W-1:0] new_sip;
    logic [IP_W-1:0] new_dip;
    logic log_valid;
    logic [3:0] log_interval;
    logic uc_route_en;
    logic mc_route_en;
    logic passthru_override;
    logic [5:0] passthru_index;
    logic dlb_enable;
    logic [9:0] dlb_index;
    logic police;
    logic [4:0] policer_index;
  } action_out_t;

endpackage : acl_action_pkg

// ### hw/sip_table_mem.sv
// Purpose: Source IP replacement table with registered read data.
// Assumes: Write port from the register bus, read port from the pipeline.
// Notes: Read data appear one clock after the address.
`timescale 1ns/1ps
`default_nettype none
module sip_table_mem
  import acl_action_pkg::*;
(
  input wire logic clk_i,
  input wire logic we_i,
  input wire logic [SIP_AW-1:0] waddr_i,
  input wire logic [IP_W-1:0] wdata_i,
  input wire logic [SIP_AW-1:0] raddr_i,
  output logic [IP_W-1:0] rdata_o
);

  logic [IP_W-1:0] mem_reg [SIP_N];

  always_ff @(posedge clk_i) begin
    if (we_i) begin
      mem_reg[waddr_i] <= wdata_i;
    end
    rdata_o <= mem_reg[raddr_i];
  end

endmodule : sip_table_mem
`default_nettype wire

// ### hw/dmac_partial_merge.sv
// Purpose: Replaces the top bits of a MAC with those of another MAC.
// Assumes: A count of zero keeps the frame address whole.
// Notes: Purely combinational.
`timescale 1ns/1ps
`default_nettype none
module dmac_partial_merge
  import acl_action_pkg::*;
(
  input wire logic [MAC_W-1:0] frame_mac_i,
  input wire logic [MAC_W-1:0] repl_mac_i,
  input wire logic [DCNT_W-1:0] count_i,
  output logic [MAC_W-1:0] merged_o
);

  // Bit b is taken from the replacement when it lies within the MSB count
  genvar b;
  generate
    for (b = 0; b < MAC_W; b++) begin : g_bit
      localparam logic [DCNT_W:0] FROM_TOP = (DCNT_W+1)'(MAC_W - b);
      wire logic take = {1'b0, count_i} >= FROM_TOP;
      assign merged_o[b] = take ? repl_mac_i[b] : frame_mac_i[b];
    end
  endgenerate

endmodule : dmac_partial_merge
`default_nettype wire

// ### hw/acl_action_decoder.sv
// Purpose: Decodes later action fields of a rule hit into frame commands.
// Assumes: One hit per valid cycle; Wishbone classic register slave.
// Notes: Two-cycle latency from act_i.valid to cmd_o.valid.
//
// Function
// R1 - Rewrite command bits 1:0 pick PTP none, one-step, two-step, time-of-day.
// R2 - Bits 3:2 add no, egress, ingress A or ingress B delay.
// R3 - Bits 5:4 pick sequence insert or Delay_Resp with/without receipt update.
// R4 - If bit 5 set, bits 5:4 are cleared toward the rewriter.
// R5 - Bit 6 sets destination MAC to the incoming source MAC.
// R6 - Bit 7 sets source MAC to the egress port configured value.
// R7 - TTL decrement enable lowers IPv4 TTL or IPv6 hop limit by one.
// R8 - Swap modes 4 to 7 make TTL enable preset TTL from swap control.
// R9 - Service-activation-only limits route swap mode to such frames.
// R10 - Mode 0x8 with that bit replaces a count of top DMAC bits.
// R11 - L4 rewrite sets destination port to tag, source port to mask.
// R12 - Logical tag goes to the header class result on CPU copy.
// R13 - Counter index picks one of 4K counters per lookup on a hit.
// R14 - MAC exchange swaps MACs unless bit 5 set, then encodes interval.
// R15 - New interval is the code, or the code minus 8 when exchange set.
// R16 - Routing mode: bit0 unicast, bit1 multicast, bit2 MAC overloading.
// R17 - Swap sub-modes 0 to 3 replace or swap MACs as defined.
// R18 - Sub-modes 4,5 add IP swap; 6 swaps IPs; 7 replaces SMAC, swaps IPs.
// R19 - Replaced MAC from replacement MAC; replaced SIP from table by index.
// R20 - With policing off, the policer index selects the SIP entry.
// R21 - Routing overload: passthru override, index, and DLB policer index.
// R22 - Timing domain select indexes the timing domain table.
// R23 - Decoded fields of one hit travel together with its frame.
`timescale 1ns/1ps
`default_nettype none
module acl_action_decoder
  import acl_action_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire action_in_t act_i,
  output action_out_t cmd_o
);

  // ***********************************
  // Register bus
  // ***********************************
  logic [31:0] swap_ip_control_reg;
  logic [31:0] egress_delay_setting_reg;
  logic [31:0] ingress_delay_set_a_reg;
  logic [31:0] ingress_delay_set_b_reg;
  logic [31:0] port_smac_lo_reg;
  logic [31:0] port_smac_hi_reg;
  logic [31:0] tdom_reg [TDOM_N];
  logic [31:0] hit_count_reg;
  logic [31:0] last_tag_reg;

  wire logic bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire logic bus_wr = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  wire logic [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                             {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire logic sel_swap = wb_adr_i == OFS_SWAP_IP_CONTROL;
  wire logic sel_edly = wb_adr_i == OFS_EGR_DELAY;
  wire logic sel_idla = wb_adr_i == OFS_IGR_DELAY_A;
  wire logic sel_idlb = wb_adr_i == OFS_IGR_DELAY_B;
  wire logic sel_smlo = wb_adr_i == OFS_PORT_SMAC_LO;
  wire logic sel_smhi = wb_adr_i == OFS_PORT_SMAC_HI;
  wire logic sel_hits = wb_adr_i == OFS_HIT_COUNT;
  wire logic sel_ltag = wb_adr_i == OFS_LAST_TAG;
  wire logic sel_sip = wb_adr_i >= OFS_SIP_BASE;
  wire logic [SIP_AW-1:0] sip_waddr = wb_adr_i[SIP_AW+1:2];
  wire logic [1:0] tdom_widx = 2'(wb_adr_i[7:2] - OFS_TDOM_BASE[7:2]);
  wire logic sel_tdom = (wb_adr_i >= OFS_TDOM_BASE)
                        & (wb_adr_i < OFS_HIT_COUNT);

  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [31:0] m);
    merge = (old_v & ~m) | (new_v & m);
  endfunction : merge

  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = REG_RESET;
    if (sel_swap) rd_mux = swap_ip_control_reg;
    if (sel_edly) rd_mux = egress_delay_setting_reg;
    if (sel_idla) rd_mux = ingress_delay_set_a_reg;
    if (sel_idlb) rd_mux = ingress_delay_set_b_reg;
    if (sel_smlo) rd_mux = port_smac_lo_reg;
    if (sel_smhi) rd_mux = port_smac_hi_reg;
    if (sel_tdom) rd_mux = tdom_reg[tdom_widx];
    if (sel_hits) rd_mux = hit_count_reg;
    if (sel_ltag) rd_mux = last_tag_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= REG_RESET;
    end else begin
      wb_ack_o <= bus_req;
      wb_dat_o <= bus_req ? rd_mux : REG_RESET;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      swap_ip_control_reg <= REG_RESET;
      egress_delay_setting_reg <= REG_RESET;
      ingress_delay_set_a_reg <= REG_RESET;
      ingress_delay_set_b_reg <= REG_RESET;
      port_smac_lo_reg <= REG_RESET;
      port_smac_hi_reg <= REG_RESET;
    end else if (bus_wr) begin
      if (sel_swap) swap_ip_control_reg <=
          merge(swap_ip_control_reg, wb_dat_i,
                bmask & 32'(2**(DCNT_LSB+DCNT_W) - 1));
      if (sel_edly) egress_delay_setting_reg <=
          merge(egress_delay_setting_reg, wb_dat_i, bmask & 32'h0000_FFFF);
      if (sel_idla) ingress_delay_set_a_reg <=
          merge(ingress_delay_set_a_reg, wb_dat_i, bmask & 32'h0000_FFFF);
      if (sel_idlb) ingress_delay_set_b_reg <=
          merge(ingress_delay_set_b_reg, wb_dat_i, bmask & 32'h0000_FFFF);
      if (sel_smlo) port_smac_lo_reg <=
          merge(port_smac_lo_reg, wb_dat_i, bmask);
      if (sel_smhi) port_smac_hi_reg <=
          merge(port_smac_hi_reg, wb_dat_i, bmask & 32'h0000_FFFF);
    end
  end

  genvar t;
  generate
    for (t = 0; t < TDOM_N; t++) begin : g_tdom
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          tdom_reg[t] <= REG_RESET;
        end else if (bus_wr && sel_tdom && tdom_widx == 2'(t)) begin
          tdom_reg[t] <= merge(tdom_reg[t], wb_dat_i,
                               bmask & 32'h0000_FFFF);
        end
      end
    end
  endgenerate

  // ***********************************
  // Stage 1: capture hit, read SIP table
  // ***********************************
  action_in_t s1_reg;
  logic [IP_W-1:0] sip_entry;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s1_reg <= '0;
    end else begin
      s1_reg <= act_i; // [R23]
    end
  end

  sip_table_mem u_sip (
    .clk_i(clk_i),
    .we_i(bus_wr & sel_sip),
    .waddr_i(sip_waddr),
    .wdata_i(wb_dat_i),
    .raddr_i(act_i.policer_index), // [R19] [R20]
    .rdata_o(sip_entry)
  );

  // ***********************************
  // Decode of the captured hit
  // ***********************************
  wire logic [7:0] rc = s1_reg.rewrite_command;
  wire logic [3:0] mode = s1_reg.route_swap_mode;
  wire logic [MAC_W-1:0] repl = s1_reg.replacement_mac;
  wire logic [MAC_W-1:0] in_smac = s1_reg.frame_smac;
  wire logic [MAC_W-1:0] in_dmac = s1_reg.frame_dmac;
  wire logic [IP_W-1:0] in_sip = s1_reg.frame_sip;
  wire logic [IP_W-1:0] in_dip = s1_reg.frame_dip;
  wire logic [MAC_W-1:0] port_smac = {port_smac_hi_reg[15:0],
                                      port_smac_lo_reg};
  wire logic [DCNT_W-1:0] dcnt =
    swap_ip_control_reg[DCNT_LSB +: DCNT_W];
  wire logic [TTL_W-1:0] ttl_preset =
    swap_ip_control_reg[TTL_LSB +: TTL_W];
  wire logic partial_dmac = (mode == MODE_DMAC_PARTIAL)
                            & s1_reg.service_activation_only; // [R10]
  wire logic mode_applies = partial_dmac
                            | ~s1_reg.service_activation_only
                            | s1_reg.service_activation_sequence; // [R9]
  wire logic swap_mode = mode[3] & mode_applies;
  wire logic route_mode = ~mode[3] & mode_applies;
  wire logic [2:0] sub = mode[2:0];
  wire logic dmac_mc = in_dmac[MAC_MC_BIT];
  wire logic dip_mc = in_dip[IP_W-1 -: 4] == IP4_MC_NIBBLE;
  wire logic ip_sub = sub[2]; // [R18]
  wire logic [MAC_W-1:0] merged_dmac;

  dmac_partial_merge u_merge (
    .frame_mac_i(in_dmac),
    .repl_mac_i(repl),
    .count_i(dcnt),
    .merged_o(merged_dmac)
  );

  // MAC and IP selection for swapping mode and the plain exchange
  logic [MAC_W-1:0] dmac_n;
  logic [MAC_W-1:0] smac_n;
  logic [IP_W-1:0] sip_n;
  logic [IP_W-1:0] dip_n;
  always_comb begin
    dmac_n = in_dmac;
    smac_n = in_smac;
    sip_n = in_sip;
    dip_n = in_dip;
    if (swap_mode) begin
      unique case (sub)
        3'h0: dmac_n = partial_dmac ? merged_dmac : repl; // [R17] [R10]
        3'h1: smac_n = repl; // [R17]
        3'h2, 3'h4: begin
          dmac_n = in_smac; // [R17] [R18]
          smac_n = dmac_mc ? repl : in_dmac; // [R19]
        end
        3'h3, 3'h5: begin
          dmac_n = dmac_mc ? in_dmac : in_smac; // [R17] [R18]
          smac_n = dmac_mc ? repl : in_dmac;
        end
        3'h6: ;
        3'h7: smac_n = repl; // [R18]
      endcase
      if (ip_sub) begin
        if (sub == 3'h5) begin
          dip_n = dip_mc ? in_dip : in_sip; // [R18]
          sip_n = dip_mc ? sip_entry : in_dip; // [R19]
        end else begin
          dip_n = in_sip; // [R18]
          sip_n = dip_mc ? sip_entry : in_dip; // [R19]
        end
      end
    end else if (s1_reg.mac_exchange_enable && !rc[5]) begin
      dmac_n = in_smac; // [R14]
      smac_n = in_dmac;
    end
    if (rc[6]) dmac_n = in_smac; // [R5]
    if (rc[7]) smac_n = port_smac; // [R6]
  end

  logic [DELAY_W-1:0] delay_n;
  always_comb begin
    unique case (rc[3:2])
      2'h0: delay_n = '0;
      2'h1: delay_n = egress_delay_setting_reg[DELAY_W-1:0]; // [R2]
      2'h2: delay_n = ingress_delay_set_a_reg[DELAY_W-1:0]; // [R2]
      2'h3: delay_n = ingress_delay_set_b_reg[DELAY_W-1:0]; // [R2]
    endcase
  end

  ttl_op_t ttl_n;
  wire logic ttl_preset_mode = swap_mode & ip_sub; // [R8]
  always_comb begin
    ttl_n = TTL_KEEP;
    if (s1_reg.ttl_decrement_enable) begin
      ttl_n = ttl_preset_mode ? TTL_PRESET : TTL_DEC; // [R7] [R8]
    end
  end

  wire logic [3:0] log_n = s1_reg.mac_exchange_enable
    ? 4'({1'b0, s1_reg.log_interval_code} - 4'(LOG_OFFSET))
    : {1'b0, s1_reg.log_interval_code}; // [R15]
  wire logic overload = route_mode & mode[2]; // [R21]

  // ***********************************
  // Stage 2: command out
  // ***********************************
  action_out_t out_n;
  always_comb begin
    out_n = '0;
    out_n.valid = s1_reg.valid; // [R23]
    out_n.rewrite_command = rc[5] ? {rc[7:6], 2'b00, rc[3:0]} : rc; // [R4]
    out_n.ptp_op = rc[1:0]; // [R1]
    out_n.delay_add = delay_n;
    out_n.seq_insert = rc[5:4] == 2'h1; // [R3]
    out_n.dresp_enable = rc[5]; // [R3]
    out_n.dresp_receipt_update = rc[5:4] == 2'h2; // [R3]
    out_n.timing_domain_cfg =
      tdom_reg[s1_reg.timing_domain_select][TDOM_W-1:0]; // [R22]
    out_n.ttl_op = ttl_n;
    out_n.ttl_value = ttl_preset;
    out_n.l4_rewrite = s1_reg.l4_port_rewrite_enable; // [R11]
    out_n.l4_dport = s1_reg.entry_logical_tag; // [R11]
    out_n.l4_sport = s1_reg.entry_tag_mask; // [R11]
    out_n.cpu_copy = s1_reg.cpu_copy_enable; // [R12]
    out_n.header_class_result = s1_reg.entry_logical_tag; // [R12]
    out_n.cnt_update = s1_reg.valid; // [R13]
    out_n.cnt_lookup = s1_reg.lookup; // [R13]
    out_n.counter_index = s1_reg.counter_index; // [R13]
    out_n.new_dmac = dmac_n;
    out_n.new_smac = smac_n;
    out_n.new_sip = sip_n;
    out_n.new_dip = dip_n;
    out_n.log_valid = rc[5] & s1_reg.delay_resp_frame
                      & in_dmac[MAC_MC_BIT]; // [R14]
    out_n.log_interval = log_n;
    out_n.uc_route_en = route_mode & mode[0]; // [R16]
    out_n.mc_route_en = route_mode & mode[1]; // [R16]
    out_n.passthru_override = overload & repl[0]; // [R21]
    out_n.passthru_index = overload ? repl[6:1] : '0; // [R21]
    out_n.dlb_enable = overload & repl[16]; // [R21]
    out_n.dlb_index = overload ? repl[26:17] : '0; // [R21]
    out_n.police = s1_reg.policer_enable; // [R20]
    out_n.policer_index = s1_reg.policer_index;
    if (!s1_reg.valid) out_n = '0;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_o <= '0;
    end else begin
      cmd_o <= out_n; // [R23]
    end
  end

  // Status: hit count and tag of the latest hit
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      hit_count_reg <= REG_RESET;
      last_tag_reg <= REG_RESET;
    end else if (s1_reg.valid) begin
      hit_count_reg <= hit_count_reg + 32'h0000_0001;
      last_tag_reg <= {16'h0000, s1_reg.entry_logical_tag};
    end
  end

endmodule : acl_action_decoder
`default_nettype wire

// ### test/rewriter_model.sv
// Purpose: Far-side rewriter model that collects decoded commands.
// Assumes: One command word per valid cycle, no back-pressure.
// Notes: The bench pops commands in arrival order.
`timescale 1ns/1ps
`default_nettype none
module rewriter_model
  import acl_action_pkg::*;
(
  input wire logic clk_i,
  input wire action_out_t cmd_i
);
  action_out_t got[$];
  always @(posedge clk_i) begin
    if (cmd_i.valid === 1'b1) begin
      got.push_back(cmd_i);
    end
  end
endmodule : rewriter_model
`default_nettype wire

// ### test/acl_action_decoder_checker.sv
// Purpose: Port-level assertions for the action decoder.
// Assumes: Two-cycle action latency, one-cycle bus answer.
// Notes: Bound into every decoder instance.
`timescale 1ns/1ps
`default_nettype none
module acl_action_decoder_checker
  import acl_action_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire action_in_t act_i,
  input wire action_out_t cmd_o
);
  // ***********************************
  // Checks
  // ***********************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  AST_LATENCY: assert property (act_i.valid |-> ##2 cmd_o.valid)
    else $error("command missing after hit");
  AST_CMD_IDLE: assert property (!cmd_o.valid |-> cmd_o == '0)
    else $error("command fields set while not valid");
  AST_PTP_OP: assert property (act_i.valid |-> ##2
    cmd_o.ptp_op == $past(act_i.rewrite_command[1:0], 2))
    else $error("ptp operation wrong");
  AST_SEQ_CLEAR: assert property (
    act_i.valid && act_i.rewrite_command[5] |-> ##2 cmd_o.dresp_enable &&
    cmd_o.rewrite_command[5:4] == 2'b00)
    else $error("sequence bits not cleared");
  AST_DMAC_FROM_SMAC: assert property (
    act_i.valid && act_i.rewrite_command[6] |->
    ##2 cmd_o.new_dmac == $past(act_i.frame_smac, 2))
    else $error("dmac not taken from smac");
  AST_L4_PORTS: assert property (
    act_i.valid && act_i.l4_port_rewrite_enable |-> ##2 cmd_o.l4_rewrite &&
    {cmd_o.l4_dport, cmd_o.l4_sport} ==
    {$past(act_i.entry_logical_tag, 2), $past(act_i.entry_tag_mask, 2)})
    else $error("l4 ports wrong");
  AST_CPU_TAG: assert property (
    act_i.valid && act_i.cpu_copy_enable |-> ##2 cmd_o.cpu_copy &&
    cmd_o.header_class_result == $past(act_i.entry_logical_tag, 2))
    else $error("class result wrong");
  AST_COUNTER: assert property (act_i.valid |-> ##2
    cmd_o.counter_index == $past(act_i.counter_index, 2))
    else $error("counter index wrong");
  AST_TTL_DEC: assert property (
    act_i.valid && act_i.ttl_decrement_enable && !act_i.route_swap_mode[3]
    |-> ##2 cmd_o.ttl_op == TTL_DEC)
    else $error("ttl not decremented");
  AST_LOG_INT: assert property (
    act_i.valid && act_i.rewrite_command[5] && act_i.delay_resp_frame &&
    act_i.frame_dmac[MAC_MC_BIT] |-> ##2 cmd_o.log_valid &&
    cmd_o.log_interval == {$past(act_i.mac_exchange_enable, 2),
    $past(act_i.log_interval_code, 2)})
    else $error("log interval wrong");
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
    wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not a one-cycle pulse");
  AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data set without ack");
  COV_B2B: cover property (act_i.valid ##1 act_i.valid);
  COV_LOG: cover property (cmd_o.log_valid);
  COV_PRESET: cover property (cmd_o.ttl_op == TTL_PRESET);
endmodule : acl_action_decoder_checker
bind acl_action_decoder acl_action_decoder_checker chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .act_i(act_i), .cmd_o(cmd_o));
`default_nettype wire

// ### test/acl_action_decoder_bench.sv
// Purpose: Self-checking bench for the action decoder.
// Assumes: Config set over Wishbone before hits are sent.
// Notes: Commands are collected by the rewriter model.
`timescale 1ns/1ps
`default_nettype none
module acl_action_decoder_bench;
  import acl_action_pkg::*;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, q;
  action_in_t act_i, x;
  action_in_t h[4];
  action_out_t cmd_o, c;
  int mismatches, total_checks, n, hits;
  acl_action_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .act_i(act_i), .cmd_o(cmd_o));
  rewriter_model rm (.clk_i(clk_i), .cmd_i(cmd_o));
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // ***********************************
  // Tasks
  // ***********************************
  task end_sim;
    if (mismatches == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  task chk(input logic [127:0] got, input logic [127:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
    wb_adr_i <= adr;
    wb_dat_i <= d;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    if (n >= 20) begin
      mismatches++;
      end_sim();
    end
  endtask : wb
  function automatic action_in_t mk(logic [7:0] rc, logic [3:0] mode);
    action_in_t r;
    r = '0;
    {r.valid, r.rewrite_command, r.route_swap_mode} = {1'b1, rc, mode};
    r.entry_logical_tag = {rc, 4'h0, mode};
    r.entry_tag_mask = ~r.entry_logical_tag;
    r.counter_index = {rc, mode};
    r.lookup = mode[0];
    {r.l4_port_rewrite_enable, r.cpu_copy_enable} = 2'b11;
    {r.ttl_decrement_enable, r.policer_index} = {1'b1, 5'd3};
    r.timing_domain_select = rc[1:0];
    r.frame_smac = 48'h0011_2233_4455;
    r.frame_dmac = 48'h0066_7788_99AA;
    r.replacement_mac = 48'h02AA_BBCC_DDEE;
    {r.frame_sip, r.frame_dip} = {32'h0A00_0001, 32'h0A00_0002};
    return r;
  endfunction : mk
  task send(input action_in_t v);
    @(posedge clk_i);
    act_i <= v;
    hits++;
  endtask : send
  task idle;
    @(posedge clk_i);
    act_i <= '0;
  endtask : idle
  task get(input action_in_t v);
    logic sw;
    sw = v.route_swap_mode[3:2] == 2'b11 &&
      (!v.service_activation_only || v.service_activation_sequence);
    n = 0;
    while (rm.got.size() == 0 && n < 10) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 10) begin
      mismatches++;
      end_sim();
    end
    c = rm.got.pop_front();
    chk(c.ptp_op, v.rewrite_command[1:0]);
    chk(c.delay_add, 16'h1111 * v.rewrite_command[3:2]);
    chk({c.seq_insert, c.dresp_enable, c.dresp_receipt_update},
      {v.rewrite_command[5:4] == 2'd1, v.rewrite_command[5],
      v.rewrite_command[5:4] == 2'd2});
    chk(c.rewrite_command, v.rewrite_command &
      (v.rewrite_command[5] ? 8'hCF : 8'hFF));
    chk({c.cnt_update, c.cnt_lookup, c.counter_index},
      {1'b1, v.lookup, v.counter_index});
    chk({c.l4_dport, c.l4_sport},
      {v.entry_logical_tag, v.entry_tag_mask});
    chk(c.header_class_result, v.entry_logical_tag);
    if (v.rewrite_command[5]) chk(c.timing_domain_cfg,
      16'h1000 + v.timing_domain_select);
    chk(c.ttl_op, !v.ttl_decrement_enable ? TTL_KEEP :
      sw ? TTL_PRESET : TTL_DEC);
  endtask : get
  task run(input action_in_t v);
    send(v);
    idle();
    get(v);
  endtask : run
  // ***********************************
  // Sequence
  // ***********************************
  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i} = 4'b1000;
    {wb_adr_i, wb_sel_i, wb_dat_i} = {8'h00, 4'hF, 32'h0};
    {act_i, mismatches, total_checks, hits} = '0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0);
      chk(q, REG_RESET);
    end
    wb(1'b1, OFS_SWAP_IP_CONTROL, 32'h0000_1040);
    wb(1'b1, OFS_EGR_DELAY, 32'h1111);
    wb(1'b1, OFS_IGR_DELAY_A, 32'h2222);
    wb(1'b1, OFS_IGR_DELAY_B, 32'h3333);
    wb(1'b1, OFS_PORT_SMAC_LO, 32'hA1B2_C3D4);
    wb(1'b1, OFS_PORT_SMAC_HI, 32'h0000_0E0F);
    for (int i = 0; i < 4; i++)
      wb(1'b1, OFS_TDOM_BASE + 8'(4 * i), 32'h1000 + i);
    wb(1'b1, OFS_SIP_BASE + 8'h0C, 32'h0A00_0003);
    wb(1'b1, 8'h40, 32'hFFFF_FFFF);
    wb(1'b0, OFS_SWAP_IP_CONTROL, 32'h0);
    chk(q, 32'h0000_1040);
    wb(1'b0, 8'h40, 32'h0);
    chk(q, 32'h0);
    wb(1'b0, OFS_SIP_BASE + 8'h0C, 32'h0);
    chk(q, 32'h0);
    for (int i = 0; i < 4; i++) h[i] = mk({2'b00, {3{2'(i)}}}, {2'b11, 2'(i)});
    h[0].ttl_decrement_enable = 1'b0;
    for (int i = 0; i < 4; i++) send(h[i]);
    idle();
    for (int i = 0; i < 4; i++) get(h[i]);
    run(mk(8'h40, 4'h0));
    chk(c.new_dmac, 48'h0011_2233_4455);
    run(mk(8'h80, 4'h0));
    chk(c.new_smac, 48'h0E0F_A1B2_C3D4);
    run(mk(8'h00, 4'h8));
    chk(c.new_dmac, 48'h02AA_BBCC_DDEE);
    x = mk(8'h00, 4'h9);
    x.service_activation_only = 1'b1;
    run(x);
    chk(c.new_smac, 48'h0011_2233_4455);
    x = mk(8'h00, 4'h8);
    x.service_activation_only = 1'b1;
    run(x);
    chk(c.new_dmac, 48'h02AA_7788_99AA);
    run(mk(8'h00, 4'hA));
    chk({c.new_dmac, c.new_smac},
      {48'h0011_2233_4455, 48'h0066_7788_99AA});
    run(mk(8'h00, 4'hE));
    chk({c.new_sip, c.new_dip, c.ttl_value},
      {64'h0A00_0002_0A00_0001, 8'h40});
    x = mk(8'h00, 4'hF);
    x.frame_dip = 32'hE000_0001;
    run(x);
    chk({c.new_sip, c.new_smac, c.police, c.policer_index},
      {32'h0A00_0003, 48'h02AA_BBCC_DDEE, 1'b0, 5'h03});
    x = mk(8'h00, 4'h5);
    x.replacement_mac = {21'h0, 10'h155, 1'b1, 9'h0, 6'h15, 1'b1};
    run(x);
    chk({c.uc_route_en, c.mc_route_en, c.passthru_override, c.passthru_index,
      c.dlb_enable, c.dlb_index}, {3'b101, 6'h15, 1'b1, 10'h155});
    x = mk(8'h00, 4'h0);
    x.mac_exchange_enable = 1'b1;
    run(x);
    chk({c.new_dmac, c.new_smac},
      {48'h0011_2233_4455, 48'h0066_7788_99AA});
    x = mk(8'h20, 4'h0);
    {x.mac_exchange_enable, x.log_interval_code, x.delay_resp_frame} = 5'b10111;
    x.frame_dmac = 48'h0100_5E00_0001;
    run(x);
    chk({c.log_valid, c.log_interval, c.new_smac},
      {1'b1, 4'hB, 48'h0011_2233_4455});
    wb(1'b0, OFS_HIT_COUNT, 32'h0);
    chk(q, 32'(hits));
    wb(1'b0, OFS_LAST_TAG, 32'h0);
    chk(q, {16'h0, x.entry_logical_tag});
    end_sim();
  end
endmodule : acl_action_decoder_bench
`default_nettype wire
